// file: pmcc_top.sv
// Power mode sequencing, clock control and external interrupt sensing
`timescale 1ns/10ps
//
// Contract
// - Wait, halt and slow clock modes exist
// - Divided clock feeds CPU and all peripherals
// - Bit 0 selects slow; normal is divide-by-two
// - Prescaler codes give divide by 4,16,8,32
// - Wait stops CPU, clears interrupt mask
// - Wait ends on interrupt, then service it
// - Halt stops oscillator and all peripherals
// - Halt with watchdog on gives watchdog reset
// - Halt entry clears the interrupt mask
// - Wake-up holds CPU 4096 CPU clocks
// - Then service waking interrupt or reset vector
// - Peripheral clock on after reset, off after interrupt
// - Bits 7:6 set groups 2,3 sensitivity
// - Bits 4:3 set groups 0,1 sensitivity
// - Bit 5 drives CPU clock onto pin
// - Control register at 0x20, read/write, resets 0
// - Halt wakes only on external or designated sources
// - Edge requests latch, clear on the group's acknowledge input
module pmcc_top import pmcc_pkg::*; #(
  parameter int unsigned STAB_COUNT = STAB_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic wait_for_irq_instr,
  input wire logic halt_instr,
  input wire logic watchdog_enabled,
  input wire logic periph_irq,
  input wire logic halt_wake_src,
  input wire logic [3:0] ext_irq_group,
  input wire logic [3:0] ext_irq_ack,
  input wire logic gpio_out,
  input wire logic gpio_oe,
  output logic clock_out_pin_o,
  output logic clock_out_pin_oe,
  output logic sys_clk,
  output logic sys_clk_tick,
  output logic cpu_run,
  output logic periph_clk_on,
  output logic osc_enable,
  output logic clear_imask,
  output logic wdg_reset_req,
  output logic service_irq,
  output logic fetch_reset,
  output logic [3:0] ext_irq_req
);

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  pmcc_ctrl_t ctrl_r;
  logic [31:0] prdata_r;
  logic hit_ctrl;
  logic hit_status;
  logic wr_ctrl;
  logic [7:0] status_word;
  pmcc_state_t state_r;
  pmcc_state_t state_nxt;
  logic wake_by_reset_r;
  logic periph_on_r;

  assign hit_ctrl = (paddr == CTRL_OFFSET);
  assign hit_status = (paddr == STATUS_OFFSET);
  assign wr_ctrl = psel && penable && pwrite && hit_ctrl;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_r <= pwdata[7:0];
    end
  end

  assign status_word = {1'b0, (state_r == ST_RUN), wake_by_reset_r, periph_on_r, ext_irq_req};

  // Read data is captured in the setup cycle so the access cycle drives a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h00000000;
    end else if (psel && !penable) begin
      if (hit_ctrl) begin
        prdata_r <= {24'h000000, ctrl_r};
      end else if (hit_status) begin
        prdata_r <= {24'h000000, status_word};
      end else begin
        prdata_r <= 32'h00000000;
      end
    end
  end

  assign prdata = prdata_r;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !(hit_ctrl || hit_status);

  // ----------------------------------------------------------------
  // System clock divider
  // ----------------------------------------------------------------
  pmcc_div_sel_t div_sel;
  logic div_clk;
  logic div_tick;

  assign div_sel.slow = ctrl_r.slow_clock_select;
  assign div_sel.psm = ctrl_r.slow_divider_select;

  pmcc_clk_div u_div (
    .pclk(pclk),
    .presetn(presetn),
    .run(osc_enable),
    .sel(div_sel),
    .div_clk(div_clk),
    .rise_tick(div_tick)
  );

  // One clock for CPU and peripherals; slow mode slows both alike
  assign sys_clk = div_clk;
  assign sys_clk_tick = div_tick;

  // ----------------------------------------------------------------
  // Clock output pin
  // ----------------------------------------------------------------
  logic pin_o_r;
  logic pin_oe_r;

  // Pin copy lags the system clock by one oscillator cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_o_r <= 1'b0;
      pin_oe_r <= 1'b0;
    end else if (ctrl_r.clock_out_enable) begin
      pin_o_r <= div_clk;
      pin_oe_r <= 1'b1;
    end else begin
      pin_o_r <= gpio_out;
      pin_oe_r <= gpio_oe;
    end
  end

  assign clock_out_pin_o = pin_o_r;
  assign clock_out_pin_oe = pin_oe_r;

  // ----------------------------------------------------------------
  // External interrupt sensing
  // ----------------------------------------------------------------
  logic [3:0] sync1_r;
  logic [3:0] sync2_r;
  logic [3:0] prev_r;
  logic [3:0] latch_r;
  logic [3:0] level_req;
  logic [1:0] group_sense [4];

  assign group_sense[0] = ctrl_r.lower_group_irq_sense;
  assign group_sense[1] = ctrl_r.lower_group_irq_sense;
  assign group_sense[2] = ctrl_r.upper_group_irq_sense;
  assign group_sense[3] = ctrl_r.upper_group_irq_sense;

  // Idle level is high, so synchronisers start high to avoid a false fall
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= 4'hf;
      sync2_r <= 4'hf;
      prev_r <= 4'hf;
    end else begin
      sync1_r <= ext_irq_group;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_grp
      logic rise;
      logic fall;
      logic hit;
      assign rise = sync2_r[g] && !prev_r[g];
      assign fall = !sync2_r[g] && prev_r[g];
      assign hit = pmcc_edge_hit(group_sense[g], rise, fall);
      // A new edge in the acknowledge cycle wins over the clear
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          latch_r[g] <= 1'b0;
        end else if (hit) begin
          latch_r[g] <= 1'b1;
        end else if (ext_irq_ack[g]) begin
          latch_r[g] <= 1'b0;
        end
      end
      assign level_req[g] = (group_sense[g] == SENSE_FALL_LOW) && !sync2_r[g];
    end
  endgenerate

  assign ext_irq_req = latch_r | level_req;

  // ----------------------------------------------------------------
  // Power mode sequencer
  // ----------------------------------------------------------------
  logic [STAB_W-1:0] stab_cnt_r;
  logic stab_done;
  logic wake_halt;
  logic wake_wait;
  logic halt_go;
  logic halt_refused;
  logic wait_go;
  logic clear_imask_r;
  logic wdg_r;
  logic service_r;
  logic fetch_r;

  assign wake_halt = (|ext_irq_req) || halt_wake_src;
  assign wake_wait = (|ext_irq_req) || periph_irq;
  assign halt_go = (state_r == ST_RUN) && halt_instr && !watchdog_enabled;
  assign halt_refused = (state_r == ST_RUN) && halt_instr && watchdog_enabled;
  assign wait_go = (state_r == ST_RUN) && !halt_instr && wait_for_irq_instr;
  assign stab_done = (state_r == ST_STAB) && div_tick && (stab_cnt_r == STAB_W'(STAB_COUNT - 1));

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN: begin
        if (halt_go) begin
          state_nxt = ST_HALT;
        end else if (wait_go) begin
          state_nxt = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (wake_wait) begin
          state_nxt = ST_RUN;
        end
      end
      ST_HALT: begin
        if (wake_halt) begin
          state_nxt = ST_STAB;
        end
      end
      ST_STAB: begin
        if (stab_done) begin
          state_nxt = ST_RUN;
        end
      end
      default: state_nxt = ST_RUN;
    endcase
  end

  // Reset counts as a wake-up: the oscillator is given its start-up time first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_STAB;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stab_cnt_r <= '0;
    end else if (state_r != ST_STAB) begin
      stab_cnt_r <= '0;
    end else if (div_tick) begin
      stab_cnt_r <= stab_cnt_r + 13'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_by_reset_r <= 1'b1;
    end else if (state_r == ST_HALT && wake_halt) begin
      wake_by_reset_r <= 1'b0;
    end
  end

  // An interrupt wake leaves peripherals unclocked; only a reset restores them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periph_on_r <= 1'b1;
    end else if (halt_go) begin
      periph_on_r <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clear_imask_r <= 1'b0;
      wdg_r <= 1'b0;
      service_r <= 1'b0;
      fetch_r <= 1'b0;
    end else begin
      clear_imask_r <= halt_go || wait_go;
      wdg_r <= halt_refused;
      service_r <= (state_r == ST_WAIT && wake_wait) || (stab_done && !wake_by_reset_r);
      fetch_r <= stab_done && wake_by_reset_r;
    end
  end

  assign cpu_run = (state_r == ST_RUN);
  assign osc_enable = (state_r != ST_HALT);
  assign periph_clk_on = periph_on_r && (state_r != ST_HALT);
  assign clear_imask = clear_imask_r;
  assign wdg_reset_req = wdg_r;
  assign service_irq = service_r;
  assign fetch_reset = fetch_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_enter_wait;
    state_r == ST_RUN && wait_for_irq_instr && !halt_instr;
  endsequence

  sequence s_enter_halt;
    state_r == ST_RUN && halt_instr && !watchdog_enabled;
  endsequence

  sequence s_halt_woken;
    state_r == ST_HALT && wake_halt;
  endsequence

  wait_entry_a: assert property (s_enter_wait |=> state_r == ST_WAIT && clear_imask && !cpu_run) else $error("wait entry wrong");
  wait_exit_a: assert property (state_r == ST_WAIT && wake_wait |=> state_r == ST_RUN && service_irq) else $error("wait exit wrong");
  halt_entry_a: assert property (s_enter_halt |=> state_r == ST_HALT && clear_imask && !osc_enable && !periph_clk_on) else $error("halt entry wrong");
  halt_refuse_a: assert property (state_r == ST_RUN && halt_instr && watchdog_enabled |=> wdg_reset_req && state_r == ST_RUN) else $error("halt not refused");
  halt_wake_a: assert property (s_halt_woken |=> state_r == ST_STAB ##1 !cpu_run [*2]) else $error("halt wake wrong");
  stab_end_a: assert property ($rose(cpu_run) && $past(state_r) == ST_STAB |-> $past(stab_cnt_r) == STAB_W'(STAB_COUNT - 1) && (fetch_reset || service_irq)) else $error("early release");
  periph_off_a: assert property (s_halt_woken ##1 (state_r == ST_STAB) [*1] |-> !periph_clk_on) else $error("peripheral clock came back");
  ctrl_write_a: assert property (wr_ctrl |=> ctrl_r == $past(pwdata[7:0])) else $error("control write lost");
  level_hold_a: assert property (ctrl_r.lower_group_irq_sense == SENSE_FALL_LOW && !sync2_r[0] |-> ext_irq_req[0]) else $error("level request dropped");
  edge_latch_a: assert property (ctrl_r.upper_group_irq_sense == SENSE_RISE && sync2_r[2] && !prev_r[2] |=> ext_irq_req[2]) else $error("edge not latched");
  clock_pin_a: assert property (ctrl_r.clock_out_enable |=> clock_out_pin_oe && clock_out_pin_o == $past(div_clk)) else $error("clock not on pin");

endmodule

// file: pmcc_pkg.sv
// Constants, types and decode helpers for the power mode and clock control block
package pmcc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 12;
  localparam logic [11:0] CTRL_OFFSET = 12'h020;
  localparam logic [11:0] STATUS_OFFSET = 12'h024;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned STAB_CYCLES = 4096;
  localparam int unsigned STAB_W = 13;
  localparam int unsigned HALF_W = 5;
  // Half periods of the system clock in oscillator cycles
  localparam logic [4:0] HALF_NORMAL = 5'h01;
  localparam logic [4:0] HALF_DIV4 = 5'h02;
  localparam logic [4:0] HALF_DIV8 = 5'h04;
  localparam logic [4:0] HALF_DIV16 = 5'h08;
  localparam logic [4:0] HALF_DIV32 = 5'h10;

  // ----------------------------------------------------------------
  // External interrupt sensitivity codes
  // ----------------------------------------------------------------
  localparam logic [1:0] SENSE_FALL_LOW = 2'h0;
  localparam logic [1:0] SENSE_RISE = 2'h1;
  localparam logic [1:0] SENSE_FALL = 2'h2;
  localparam logic [1:0] SENSE_BOTH = 2'h3;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] upper_group_irq_sense;
    logic clock_out_enable;
    logic [1:0] lower_group_irq_sense;
    logic [1:0] slow_divider_select;
    logic slow_clock_select;
  } pmcc_ctrl_t;

  typedef struct packed {
    logic slow;
    logic [1:0] psm;
  } pmcc_div_sel_t;

  typedef enum logic [1:0] {ST_RUN, ST_WAIT, ST_HALT, ST_STAB} pmcc_state_t;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic logic [4:0] pmcc_half_period(input pmcc_div_sel_t s);
    logic [4:0] h;
    h = HALF_NORMAL;
    if (s.slow) begin
      case (s.psm)
        2'h0: h = HALF_DIV4;
        2'h1: h = HALF_DIV16;
        2'h2: h = HALF_DIV8;
        default: h = HALF_DIV32;
      endcase
    end
    return h;
  endfunction

  function automatic logic pmcc_edge_hit(input logic [1:0] sense, input logic rise, input logic fall);
    logic hit;
    hit = 1'b0;
    case (sense)
      SENSE_RISE: hit = rise;
      SENSE_BOTH: hit = rise | fall;
      default: hit = fall;
    endcase
    return hit;
  endfunction

endpackage

// file: pmcc_clk_div.sv
// Glitch-free system clock divider
`timescale 1ns/10ps
module pmcc_clk_div import pmcc_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input pmcc_div_sel_t sel,
  output logic div_clk,
  output logic rise_tick
);

  // ----------------------------------------------------------------
  // Counter and output phase
  // ----------------------------------------------------------------
  logic [HALF_W-1:0] half_r;
  logic [HALF_W-1:0] cnt_r;
  logic div_clk_r;
  logic tick_r;
  logic last;

  assign last = (cnt_r == (half_r - 5'h01));

  // Frozen while the oscillator is off, so no edge leaks during halt
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
    end else if (run) begin
      cnt_r <= last ? '0 : cnt_r + 5'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_clk_r <= 1'b0;
      tick_r <= 1'b0;
    end else begin
      tick_r <= run && last && !div_clk_r;
      if (run && last) begin
        div_clk_r <= ~div_clk_r;
      end
    end
  end

  // New ratio only at the end of a low phase: both halves of the next period use it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_r <= HALF_NORMAL;
    end else if (run && last && !div_clk_r) begin
      half_r <= pmcc_half_period(sel);
    end
  end

  assign div_clk = div_clk_r;
  assign rise_tick = tick_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  ratio_switch_a: assert property ($changed(half_r) |-> $rose(div_clk_r)) else $error("ratio changed mid period");
  tick_edge_a: assert property (tick_r |-> $rose(div_clk_r)) else $error("tick not on rising edge");

endmodule

// file: pmcc_top_tb.sv
// Self-checking testbench for the power mode and clock control block
`timescale 1ns/10ps
module pmcc_top_tb import pmcc_pkg::*; ;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic wait_for_irq_instr, halt_instr, watchdog_enabled, periph_irq, halt_wake_src;
  logic [3:0] ext_irq_group, ext_irq_ack, ext_irq_req;
  logic gpio_out, gpio_oe, clock_out_pin_o, clock_out_pin_oe, sys_clk, sys_clk_tick;
  logic cpu_run, periph_clk_on, osc_enable, clear_imask, wdg_reset_req, service_irq, fetch_reset;
  logic e, s;
  logic [1:0] c;
  logic [1:0] codes [4] = '{SENSE_FALL_LOW, SENSE_FALL, SENSE_RISE, SENSE_BOTH};
  int n_fail = 0;
  int num_checks = 0;
  int t, i, k;
  // Small wake-up count keeps the run short
  localparam int unsigned STAB = 4;

  pmcc_top #(.STAB_COUNT(STAB)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wait_for_irq_instr(wait_for_irq_instr), .halt_instr(halt_instr), .watchdog_enabled(watchdog_enabled),
    .periph_irq(periph_irq), .halt_wake_src(halt_wake_src), .ext_irq_group(ext_irq_group),
    .ext_irq_ack(ext_irq_ack), .gpio_out(gpio_out), .gpio_oe(gpio_oe), .clock_out_pin_o(clock_out_pin_o),
    .clock_out_pin_oe(clock_out_pin_oe), .sys_clk(sys_clk), .sys_clk_tick(sys_clk_tick), .cpu_run(cpu_run),
    .periph_clk_on(periph_clk_on), .osc_enable(osc_enable), .clear_imask(clear_imask),
    .wdg_reset_req(wdg_reset_req), .service_irq(service_irq), .fetch_reset(fetch_reset),
    .ext_irq_req(ext_irq_req));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp, input string msg);
    chk({31'h0, got}, {31'h0, exp}, msg);
  endtask

  // Hung waits are fatal to the run, so they end it through the closing report
  task automatic hang(input string msg);
    n_fail++;
    $display("MISMATCH t=%0t timeout %s", $time, msg);
    close_out();
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) hang("apb");
  endtask

  // Waits for tick (0), service entry (1) or reset fetch (2); counts ticks before it
  task automatic wait_ev(input int sel, input int lim, output int ticks);
    int n;
    logic hit;
    ticks = 0;
    hit = 1'b0;
    for (n = 0; n < lim && !hit; n++) begin
      @(posedge pclk);
      #1;
      hit = ((sel == 0) ? sys_clk_tick : (sel == 1) ? service_irq : fetch_reset) === 1'b1;
      if (!hit && sys_clk_tick === 1'b1) ticks++;
    end
    if (!hit) hang("event");
  endtask

  task automatic period(input int exp, input string msg);
    int n;
    int tk;
    // The new ratio lands on a later rising edge, so skip one whole period
    wait_ev(0, 100, tk);
    wait_ev(0, 100, tk);
    n = 0;
    do begin
      @(posedge pclk);
      #1;
      n++;
    end while (sys_clk_tick !== 1'b1 && n < 100);
    if (sys_clk_tick !== 1'b1) hang("period");
    chk(32'(n), 32'(exp), msg);
  endtask

  task automatic instr(input logic h);
    @(posedge pclk);
    if (h) halt_instr <= 1'b1;
    else wait_for_irq_instr <= 1'b1;
    @(posedge pclk);
    halt_instr <= 1'b0;
    wait_for_irq_instr <= 1'b0;
    #1;
  endtask

  task automatic ack_all;
    @(posedge pclk);
    ext_irq_ack <= 4'hf;
    @(posedge pclk);
    ext_irq_ack <= 4'h0;
    repeat (2) @(posedge pclk);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {wait_for_irq_instr, halt_instr, watchdog_enabled, periph_irq, halt_wake_src} = '0;
    ext_irq_group = 4'hf;
    ext_irq_ack = 4'h0;
    gpio_out = 1'b0;
    gpio_oe = 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    wait_ev(2, 200, t);
    chk(32'(t), 32'(STAB), "reset hold ticks");
    chk1(cpu_run, 1'b1, "run after reset");
    apb(1'b0, CTRL_OFFSET, 32'h0, q, e);
    chk(q, 32'h0, "ctrl reset");
    $display("test reset done");

    apb(1'b1, CTRL_OFFSET, 32'h0000_00a5, q, e);
    apb(1'b0, CTRL_OFFSET, 32'h0, q, e);
    chk(q, 32'h0000_00a5, "ctrl rw");
    apb(1'b1, 12'h030, 32'h0000_00ff, q, e);
    chk1(e, 1'b1, "unmapped write err");
    apb(1'b0, 12'h030, 32'h0, q, e);
    chk1(e, 1'b1, "unmapped read err");
    apb(1'b0, CTRL_OFFSET, 32'h0, q, e);
    chk(q, 32'h0000_00a5, "ctrl kept");
    $display("test registers done");

    apb(1'b1, CTRL_OFFSET, 32'h0, q, e);
    period(2, "normal divide");
    apb(1'b1, CTRL_OFFSET, 32'h1, q, e);
    period(4, "slow 00");
    apb(1'b1, CTRL_OFFSET, 32'h3, q, e);
    period(16, "slow 01");
    apb(1'b1, CTRL_OFFSET, 32'h5, q, e);
    period(8, "slow 10");
    apb(1'b1, CTRL_OFFSET, 32'h7, q, e);
    period(32, "slow 11");
    apb(1'b1, CTRL_OFFSET, 32'h6, q, e);
    period(2, "back to normal");
    $display("test divider done");

    apb(1'b1, CTRL_OFFSET, 32'h20, q, e);
    repeat (3) @(posedge pclk);
    #1;
    s = sys_clk;
    for (i = 0; i < 6; i++) begin
      @(posedge pclk);
      #1;
      chk1(clock_out_pin_o, s, "clock out level");
      chk1(clock_out_pin_oe, 1'b1, "clock out drive");
      s = sys_clk;
    end
    @(posedge pclk);
    gpio_out <= 1'b1;
    gpio_oe <= 1'b1;
    apb(1'b1, CTRL_OFFSET, 32'h0, q, e);
    repeat (3) @(posedge pclk);
    #1;
    chk1(clock_out_pin_o, 1'b1, "pin as gpio");
    chk1(clock_out_pin_oe, 1'b1, "pin gpio drive");
    @(posedge pclk);
    gpio_oe <= 1'b0;
    repeat (3) @(posedge pclk);
    #1;
    chk1(clock_out_pin_oe, 1'b0, "pin gpio release");
    $display("test clock out done");

    for (k = 0; k < 4; k++) begin
      c = codes[k];
      apb(1'b1, CTRL_OFFSET, {24'h0, c, 1'b0, c, 3'h0}, q, e);
      ack_all();
      @(posedge pclk);
      ext_irq_group <= 4'h0;
      repeat (5) @(posedge pclk);
      #1;
      chk({28'h0, ext_irq_req}, (c != SENSE_RISE) ? 32'hf : 32'h0, "falling edge");
      ack_all();
      #1;
      chk({28'h0, ext_irq_req}, (c == SENSE_FALL_LOW) ? 32'hf : 32'h0, "after ack low");
      @(posedge pclk);
      ext_irq_group <= 4'hf;
      repeat (5) @(posedge pclk);
      #1;
      chk({28'h0, ext_irq_req}, (c == SENSE_RISE || c == SENSE_BOTH) ? 32'hf : 32'h0, "rising edge");
      ack_all();
      #1;
      chk({28'h0, ext_irq_req}, 32'h0, "cleared");
    end
    $display("test irq sense done");

    apb(1'b1, CTRL_OFFSET, 32'h0, q, e);
    instr(1'b0);
    chk1(cpu_run, 1'b0, "wait stops cpu");
    chk1(clear_imask, 1'b1, "wait clears mask");
    chk1(periph_clk_on, 1'b1, "wait keeps peripherals");
    @(posedge pclk);
    periph_irq <= 1'b1;
    wait_ev(1, 10, t);
    chk1(cpu_run, 1'b1, "wait wake");
    @(posedge pclk);
    periph_irq <= 1'b0;
    $display("test wait done");

    watchdog_enabled <= 1'b1;
    instr(1'b1);
    chk1(wdg_reset_req, 1'b1, "halt watchdog reset");
    chk1(cpu_run, 1'b1, "no halt with watchdog");
    @(posedge pclk);
    watchdog_enabled <= 1'b0;
    instr(1'b1);
    chk1(osc_enable, 1'b0, "halt stops osc");
    chk1(periph_clk_on, 1'b0, "halt stops peripherals");
    chk1(clear_imask, 1'b1, "halt clears mask");
    @(posedge pclk);
    periph_irq <= 1'b1;
    repeat (10) @(posedge pclk);
    #1;
    chk1(osc_enable, 1'b0, "peripheral irq no halt wake");
    @(posedge pclk);
    periph_irq <= 1'b0;
    ext_irq_group <= 4'hd;
    wait_ev(1, 200, t);
    chk(32'(t), 32'(STAB), "halt wake ticks");
    chk1(cpu_run, 1'b1, "halt wake run");
    chk1(periph_clk_on, 1'b0, "irq wake peripherals off");
    apb(1'b0, STATUS_OFFSET, 32'h0, q, e);
    chk(q, 32'h0000_0042, "status after irq wake");
    chk1(e, 1'b0, "status read no err");
    @(posedge pclk);
    ext_irq_group <= 4'hf;
    ack_all();
    $display("test halt done");

    apb(1'b1, CTRL_OFFSET, 32'hff, q, e);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    wait_ev(2, 200, t);
    chk(32'(t), 32'(STAB), "second reset ticks");
    chk1(periph_clk_on, 1'b1, "reset wake peripherals on");
    apb(1'b0, CTRL_OFFSET, 32'h0, q, e);
    chk(q, 32'h0, "ctrl reset again");
    $display("test second reset done");
    close_out();
  end
endmodule
